// ==== test/camera_trigger_strobe_control_tb.sv ====
`timescale 1ns/1ps
module camera_trigger_strobe_control_tb import trig_flash_pkg::*; ;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, trig_in_a, trig_in_b;
	logic awready, wready, bvalid, arready, rvalid, exposure_active, clr, want_a, want_b;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb, port_out;
	logic [1:0] bresp, rresp;
	logic [31:0] m [16];
	int on_cnt [5];
	int first_on [5];
	int failures, num_checks;
	localparam logic [7:0] RA [11] = '{8'h0, 8'h8, 8'hc, 8'h10, 8'h14, 8'h20, 8'h24, 8'h28,
		8'h2c, 8'h18, 8'h40};
	localparam logic [31:0] TBV [4] = '{32'h0, 32'h55, 32'h56, 32'h1};
	localparam logic [31:0] FC [4] = '{32'h30002001, 32'h10001000, 32'h20002000, 32'h30000001};
	localparam logic [31:0] LV [3] = '{32'h10001, 32'h10101, 32'h10000};

	trig_flash_ctrl u_trig_flash_ctrl (.*);
	trig_flash_far_model u_trig_flash_far_model (.*);

	// Free-running clock, 5 ns period.
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// Timing is judged within a small window, since pin synchronisers add fixed lag.
	task automatic chk_rng(input int got, input int lo, input int hi);
		chk((got >= lo && got <= hi) ? 32'(lo) : 32'(got), 32'(lo));
	endtask : chk_rng

	task automatic end_sim;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// Reference register model: returns the expected response and applies accepted writes.
	function automatic logic [1:0] mwr(input logic [7:0] a, input logic [31:0] d);
		logic ok;
		ok = 1'b1;
		case (a)
			ADDR_TRIG_CTRL: ok = d[10:8] inside {TRIG_SRC_INPUT_A, TRIG_SRC_INPUT_B, TRIG_SRC_SOFT};
			ADDR_SOFT_TRIG: d = 32'h0;
			ADDR_STATUS: d = 32'h0;
			ADDR_SHUTTER: ok = d[15:0] != 16'h0;
			ADDR_TIMEBASE: ok = d >= 32'h1 && d <= 32'h55;
			ADDR_PORT_SRC: for (int i = 0; i < 4; i++) ok &= d[8*i+:3] inside {3'h0, 3'h1, 3'h3, 3'h4};
			default: ok = a[7:4] == ADDR_FLASH_HI && m[4][8*a[3:2]+:3] == PORT_SRC_STROBE;
		endcase
		if (ok) m[a[5:2]] = d;
		return ok ? RESP_OKAY : RESP_SLVERR;
	endfunction : mwr

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] e;
		e = mwr(a, d);
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) bready <= 1'b1;
		end while (!(bvalid && bready));
		chk(32'(bresp), 32'(e));
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		logic [31:0] d;
		logic [1:0] e;
		d = m[a[5:2]];
		e = RESP_OKAY;
		if (a[7:4] == ADDR_FLASH_HI && m[4][8*a[3:2]+:3] != PORT_SRC_STROBE) e = RESP_SLVERR;
		if (a[7:4] != ADDR_FLASH_HI && a > ADDR_STATUS) {d, e} = {32'h0, RESP_SLVERR};
		arvalid <= 1'b1;
		araddr <= a;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) rready <= 1'b1;
		end while (!(rvalid && rready));
		chk(rdata, d);
		chk(32'(rresp), 32'(e));
		rready <= 1'b0;
	endtask : rd

	task automatic clear_lamps;
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
	endtask : clear_lamps

	// Main sequence.
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, clr, want_a, want_b, aresetn} = '0;
		{awaddr, araddr, wdata, wstrb} = {16'h0, 32'h0, 4'hf};
		{failures, num_checks} = '0;
		m = '{0: 32'h10000, 2: 32'hc8, 3: 32'h1, 8: 32'h20000000, 9: 32'h20000000,
			10: 32'h20000000, 11: 32'h20000000, default: 32'h0};
		void'($urandom(32'h8928));
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		foreach (RA[i]) rd(RA[i]);
		for (int s = 0; s < 8; s++) begin
			wr(ADDR_TRIG_CTRL, 32'h10000 | (s << 8));
			rd(ADDR_TRIG_CTRL);
		end
		foreach (TBV[i]) wr(ADDR_TIMEBASE, TBV[i]);
		rd(ADDR_TIMEBASE);
		wr(8'h24, 32'h30001001);
		wr(ADDR_SHUTTER, 32'h0);
		wr(8'h18, 32'h1);
		wr(ADDR_PORT_SRC, 32'h04040404);
		for (int i = 0; i < 4; i++) begin
			wr(8'h20 + 8'(4 * i), $urandom & 32'h30ffffff);
			rd(8'h20 + 8'(4 * i));
		end
		wr(ADDR_SHUTTER, 32'h12c);
		foreach (FC[i]) wr(8'h20 + 8'(4 * i), FC[i]);
		repeat (3) @(posedge aclk);
		chk({28'h0, port_out}, 32'h2);
		clear_lamps();
		wr(ADDR_TRIG_CTRL, 32'h701);
		wr(ADDR_SOFT_TRIG, 32'h1);
		repeat (1000) @(posedge aclk);
		chk_rng(on_cnt[4], 299, 301);
		chk_rng(on_cnt[0], 399, 401);
		chk_rng(on_cnt[1], 199, 201);
		chk_rng(on_cnt[2], 0, 0);
		chk_rng(on_cnt[3], 0, 0);
		chk_rng(first_on[0] - first_on[4], 199, 203);
		chk_rng(first_on[1] - first_on[4], 0, 3);
		// Level mode from each pin, then with triggering disabled.
		for (int j = 0; j < 3; j++) begin
			wr(ADDR_TRIG_CTRL, LV[j]);
			clear_lamps();
			want_a <= (j != 1);
			want_b <= (j == 1);
			repeat (50) @(posedge aclk);
			{want_a, want_b} <= 2'b00;
			repeat (20) @(posedge aclk);
			chk_rng(on_cnt[4], j < 2 ? 49 : 0, j < 2 ? 51 : 0);
		end
		// Programmable mode from a pin, with the other port sources in use.
		wr(ADDR_PORT_SRC, 32'h04830100);
		rd(ADDR_PORT_SRC);
		wr(ADDR_TRIG_CTRL, 32'h1);
		clear_lamps();
		want_a <= 1'b1;
		repeat (5) @(posedge aclk);
		want_a <= 1'b0;
		repeat (400) @(posedge aclk);
		chk_rng(on_cnt[4], 299, 301);
		chk_rng(on_cnt[0], 299, 301);
		chk_rng(on_cnt[1], 299, 301);
		chk({28'h0, port_out}, 32'h6);
		end_sim();
	end

	// Watchdog, well beyond the expected run of under two thousand cycles.
	initial begin
		#200000;
		failures++;
		end_sim();
	end
endmodule : camera_trigger_strobe_control_tb

// ==== test/trig_flash_ctrl_checker.sv ====
`timescale 1ns/1ps
module trig_flash_ctrl_checker import trig_flash_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [7:0] araddr,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic trig_in_a,
	input wire logic trig_in_b,
	input wire logic [3:0] port_out,
	input wire logic exposure_active
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// A write taken whole answers two edges later, never sooner.
	sequence s_wr_taken; awvalid && awready && wvalid && wready; endsequence
	sequence s_b_answer; !bvalid ##1 bvalid; endsequence
	property p_wr_lat; s_wr_taken |=> s_b_answer; endproperty
	a_wr_lat: assert property (p_wr_lat) else $error("write answer off time");
	property p_rd_lat; arvalid && arready |=> rvalid; endproperty
	a_rd_lat: assert property (p_rd_lat) else $error("read answer late");
	property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	property p_w_refuse; bvalid |-> !awready && !wready; endproperty
	a_w_refuse: assert property (p_w_refuse) else $error("write taken while busy");
	property p_r_refuse; rvalid |-> !arready; endproperty
	a_r_refuse: assert property (p_r_refuse) else $error("read taken while busy");
	property p_hole;
		arvalid && arready && (araddr inside {8'h18, 8'h1c} || araddr >= 8'h30)
			|=> rresp == RESP_SLVERR && rdata == 32'h0;
	endproperty
	a_hole: assert property (p_hole) else $error("unmapped read answered");
	property p_rst; $rose(aresetn) |-> port_out == 4'h0 && !exposure_active && !bvalid; endproperty
	a_rst: assert property (p_rst) else $error("outputs busy after reset");
endmodule : trig_flash_ctrl_checker

bind trig_flash_ctrl trig_flash_ctrl_checker u_trig_flash_ctrl_checker (.*);

// ==== test/trig_flash_far_model.sv ====
`timescale 1ns/1ps
module trig_flash_far_model (
	input wire logic aclk,
	input wire logic clr,
	input wire logic want_a,
	input wire logic want_b,
	input wire logic [3:0] port_out,
	input wire logic exposure_active,
	output logic trig_in_a,
	output logic trig_in_b,
	output int on_cnt [5],
	output int first_on [5]
);
	int cyc;
	logic [4:0] idle;
	logic [4:0] seen;
	assign seen = {exposure_active, port_out};
	// Trigger pins move just after an edge, as a sensor output would.
	always @(posedge aclk) begin
		trig_in_a <= want_a;
		trig_in_b <= want_b;
	end
	// Lamps count cycles away from the level seen when cleared, so polarity needs no input.
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (clr) begin
			idle <= seen;
			on_cnt <= '{default: 0};
			first_on <= '{default: -1};
		end else for (int i = 0; i < 5; i++) if (seen[i] !== idle[i]) begin
			on_cnt[i] <= on_cnt[i] + 1;
			if (first_on[i] < 0) first_on[i] <= cyc;
		end
	end
endmodule : trig_flash_far_model

// ==== verilog/trig_flash_ctrl.sv ====
`timescale 1ns/1ps
module trig_flash_ctrl import trig_flash_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic awvalid,
	output logic awready,
	input wire logic [7:0] awaddr,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [7:0] araddr,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	input wire logic trig_in_a,
	input wire logic trig_in_b,
	output logic [3:0] port_out,
	output logic exposure_active
);

	// The whole block state lives in one packed struct so reset and the register
	// step stay in one place; n is the value that s takes at the next edge.
	state_t s;
	state_t n;
	logic wr_fire;
	logic [31:0] wr_old;
	logic [31:0] wr_val;
	logic wr_ok;
	logic trig_lvl;
	logic trig_on;
	logic trig_rise;
	logic exp_start;
	logic tick;
	logic [1:0] ch;

	// Register view of the whole state, shared by reads and byte merges.
	// One view for both paths means a partial write merges into exactly what
	// a read would return, so unused bits read back as zero, except in the port source word, which is stored whole.
	function automatic logic [31:0] reg_view(input state_t st, input logic [7:0] a);
		logic [31:0] v;
		logic [1:0] i;
		v = 32'h0;
		i = a[3:2];
		if (a[7:4] == ADDR_FLASH_HI) begin
			v[FLASH_DELAY_LSB +: 12] = st.cfg[i].delay;
			v[FLASH_WIDTH_LSB +: 12] = st.cfg[i].width;
			v[FLASH_EN_BIT] = st.cfg[i].enable;
			v[FLASH_POL_BIT] = st.cfg[i].polarity;
		end else begin
			case (a)
				ADDR_TRIG_CTRL: begin
					v[TRIG_EN_BIT] = st.trig_en;
					v[TRIG_SRC_LSB +: 3] = st.trig_src;
					v[TRIG_MODE_BIT] = st.exp_mode;
				end
				ADDR_SHUTTER: v[15:0] = st.shutter;
				ADDR_TIMEBASE: v[6:0] = st.timebase;
				ADDR_PORT_SRC: v = st.port_src;
				// Status shows the synchronised pins, never the raw inputs.
				ADDR_STATUS: begin
					v[0] = st.exposing;
					v[4:1] = st.port_out;
					v[5] = st.sync_a[1];
					v[6] = st.sync_b[1];
				end
				default: v = 32'h0;
			endcase
		end
		return v;
	endfunction : reg_view

	// Known addresses answer OKAY unless a value or strobe-port check refuses the access; anything else is an error.
	// The status word is known, so a write to it answers OKAY and changes nothing.
	function automatic logic addr_known(input logic [7:0] a);
		return (a[7:4] == ADDR_FLASH_HI) || (a == ADDR_TRIG_CTRL) ||
			(a == ADDR_SOFT_TRIG) || (a == ADDR_SHUTTER) ||
			(a == ADDR_TIMEBASE) || (a == ADDR_PORT_SRC) || (a == ADDR_STATUS);
	endfunction : addr_known

	// Port source codes that the output ports accept.
	function automatic logic port_code_ok(input logic [2:0] c);
		return (c == PORT_SRC_INTEGRATE) || (c == PORT_SRC_READY) ||
			(c == PORT_SRC_USER) || (c == PORT_SRC_STROBE);
	endfunction : port_code_ok

	// Handshake outputs are combinational; payloads come from the state.
	// Holding the address and data channels off while a response waits keeps
	// one write in flight at a time without any queue.
	assign awready = !s.aw_held && !s.bvalid;
	assign wready = !s.w_held && !s.bvalid;
	assign arready = !s.rvalid;
	assign bvalid = s.bvalid;
	assign bresp = s.bresp;
	assign rvalid = s.rvalid;
	assign rdata = s.rdata;
	assign rresp = s.rresp;
	assign port_out = s.port_out;
	assign exposure_active = s.exposing;

	// A write runs once both address and data are held, so they may come in either order.
	// The response then waits for bready, and no new write address or data is taken meanwhile.
	assign wr_fire = s.aw_held && s.w_held && !s.bvalid;
	assign ch = s.aw_addr[3:2];

	// Byte-lane merge of the held data into the current register word.
	always_comb begin
		wr_old = reg_view(s, s.aw_addr);
		for (int b = 0; b < 4; b++) begin
			wr_val[8*b +: 8] = s.w_strb[b] ? s.w_data[8*b +: 8] : wr_old[8*b +: 8];
		end
	end

	// Values out of range or strobe writes on a non-strobe port are refused unchanged.
	// The merged word is judged rather than the raw data, so byte writes are
	// checked against the value that would really land.
	always_comb begin
		wr_ok = addr_known(s.aw_addr);
		if (s.aw_addr[7:4] == ADDR_FLASH_HI) begin
			wr_ok = s.port_src[ch][2:0] == PORT_SRC_STROBE;
		end else begin
			case (s.aw_addr)
				ADDR_TRIG_CTRL: begin
					wr_ok = (wr_val[TRIG_SRC_LSB +: 3] == TRIG_SRC_INPUT_A) ||
						(wr_val[TRIG_SRC_LSB +: 3] == TRIG_SRC_INPUT_B) ||
						(wr_val[TRIG_SRC_LSB +: 3] == TRIG_SRC_SOFT);
				end
				ADDR_SHUTTER: wr_ok = wr_val[15:0] != 16'h0;
				ADDR_TIMEBASE: begin
					wr_ok = (wr_val[31:0] >= 32'(TIMEBASE_MIN)) &&
						(wr_val[31:0] <= 32'(TIMEBASE_MAX));
				end
				ADDR_PORT_SRC: begin
					for (int p = 0; p < 4; p++) begin
						if (!port_code_ok(wr_val[8*p +: 3])) begin
							wr_ok = 1'b0;
						end
					end
				end
				default: wr_ok = addr_known(s.aw_addr);
			endcase
		end
	end

	// Selected trigger level; the software trigger is a one-cycle pulse.
	// The default arm keeps the trigger quiet should the field ever hold a refused code.
	always_comb begin
		case (s.trig_src)
			TRIG_SRC_INPUT_A: trig_lvl = s.sync_a[1];
			TRIG_SRC_INPUT_B: trig_lvl = s.sync_b[1];
			TRIG_SRC_SOFT: trig_lvl = s.soft_pulse;
			default: trig_lvl = 1'b0;
		endcase
	end

	// The edge detector starts from zero after reset, the idle pin level, so no
	// false trigger follows reset; a tick ends one strobe unit.
	assign trig_on = s.trig_en && trig_lvl;
	assign trig_rise = trig_on && !s.trig_prev;
	assign tick = (s.unit_cnt >= FLASH_UNIT_CYCLES - 8'h01) &&
		(s.tb_cnt >= s.timebase - 7'h01);

	// Next-state logic for the bus slave, trigger, exposure and strobe channels.
	always_comb begin
		n = s;
		n.sync_a = {s.sync_a[0], trig_in_a};
		n.sync_b = {s.sync_b[0], trig_in_b};
		n.soft_pulse = 1'b0;
		n.trig_prev = trig_on;

		// Write address and data channels.
		if (awvalid && awready) begin
			n.aw_held = 1'b1;
			n.aw_addr = awaddr;
		end
		if (wvalid && wready) begin
			n.w_held = 1'b1;
			n.w_data = wdata;
			n.w_strb = wstrb;
		end
		if (s.bvalid && bready) begin
			n.bvalid = 1'b0;
		end
		if (wr_fire) begin
			n.aw_held = 1'b0;
			n.w_held = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end
		if (wr_fire && wr_ok) begin
			if (s.aw_addr[7:4] == ADDR_FLASH_HI) begin
				n.cfg[ch].delay = wr_val[FLASH_DELAY_LSB +: 12];
				n.cfg[ch].width = wr_val[FLASH_WIDTH_LSB +: 12];
				n.cfg[ch].enable = wr_val[FLASH_EN_BIT];
				n.cfg[ch].polarity = wr_val[FLASH_POL_BIT];
			end else begin
				case (s.aw_addr)
					ADDR_TRIG_CTRL: begin
						n.trig_en = wr_val[TRIG_EN_BIT];
						n.trig_src = wr_val[TRIG_SRC_LSB +: 3];
						n.exp_mode = wr_val[TRIG_MODE_BIT];
					end
					ADDR_SOFT_TRIG: n.soft_pulse = s.w_strb[0] && s.w_data[0];
					ADDR_SHUTTER: n.shutter = wr_val[15:0];
					ADDR_TIMEBASE: n.timebase = wr_val[6:0];
					ADDR_PORT_SRC: n.port_src = wr_val;
					default: n.soft_pulse = 1'b0;
				endcase
			end
		end

		// Read channel answers one cycle after the address is taken.
		// A strobe read on a port that is no strobe source still returns the stored word.
		if (s.rvalid && rready) begin
			n.rvalid = 1'b0;
		end
		if (arvalid && arready) begin
			n.rvalid = 1'b1;
			n.rdata = reg_view(s, araddr);
			n.rresp = RESP_OKAY;
			if (!addr_known(araddr)) begin
				n.rresp = RESP_SLVERR;
			end else if (araddr[7:4] == ADDR_FLASH_HI &&
				s.port_src[araddr[3:2]][2:0] != PORT_SRC_STROBE) begin
				n.rresp = RESP_SLVERR;
			end
		end

		// Exposure: level mode follows the pin; otherwise a fixed shutter length.
		// Retriggers during a programmed exposure are ignored, and clearing the
		// enable ends any exposure at once, whatever the mode.
		// The software trigger is a single pulse, so it always takes the shutter path.
		if (!s.trig_en) begin
			n.exposing = 1'b0;
			n.exp_cnt = 16'h0;
		end else if (s.exp_mode == EXPOSURE_LEVEL && s.trig_src != TRIG_SRC_SOFT) begin
			n.exposing = trig_on;
		end else if (s.exposing) begin
			n.exposing = s.exp_cnt > 16'h1;
			n.exp_cnt = s.exp_cnt - 16'h1;
		end else if (trig_rise) begin
			n.exposing = 1'b1;
			n.exp_cnt = s.shutter;
		end
		exp_start = n.exposing && !s.exposing;

		// Time-base prescaler restarts at each exposure so delays line up with it.
		// The first unit after an exposure start is therefore whole, never partial.
		if (exp_start || tick) begin
			n.unit_cnt = 8'h0;
			n.tb_cnt = 7'h0;
		end else if (s.unit_cnt >= FLASH_UNIT_CYCLES - 8'h01) begin
			n.unit_cnt = 8'h0;
			n.tb_cnt = s.tb_cnt + 7'h1;
		end else begin
			n.unit_cnt = s.unit_cnt + 8'h1;
		end

		// Each channel waits its delay, then holds its pulse for the width.
		// Leaving the strobe source or clearing the enable drops the pulse at once
		// rather than letting it finish, so a lamp is never left lit by stale settings.
		// A zero width means no pulse at all, even after a nonzero delay.
		for (int i = 0; i < 4; i++) begin
			if (!s.cfg[i].enable || s.port_src[i][2:0] != PORT_SRC_STROBE) begin
				n.phase[i] = FLASH_IDLE;
			end else if (exp_start) begin
				if (s.cfg[i].delay != 12'h0) begin
					n.phase[i] = FLASH_WAIT;
					n.cnt[i] = s.cfg[i].delay;
				end else if (s.cfg[i].width != 12'h0) begin
					n.phase[i] = FLASH_ON;
					n.cnt[i] = s.cfg[i].width;
				end else begin
					n.phase[i] = FLASH_IDLE;
				end
			end else if (tick) begin
				case (s.phase[i])
					FLASH_WAIT: begin
						if (s.cnt[i] > 12'h1) begin
							n.cnt[i] = s.cnt[i] - 12'h1;
						end else if (s.cfg[i].width != 12'h0) begin
							n.phase[i] = FLASH_ON;
							n.cnt[i] = s.cfg[i].width;
						end else begin
							n.phase[i] = FLASH_IDLE;
						end
					end
					FLASH_ON: begin
						n.cnt[i] = s.cnt[i] - 12'h1;
						if (s.cnt[i] <= 12'h1) begin
							n.phase[i] = FLASH_IDLE;
						end
					end
					default: n.phase[i] = FLASH_IDLE;
				endcase
			end

			// Output port mux; an idle strobe sits at its inactive level.
			// The mux reads registered state, so each port lags its source by one cycle.
			case (s.port_src[i][2:0])
				PORT_SRC_INTEGRATE: n.port_out[i] = s.exposing;
				PORT_SRC_READY: n.port_out[i] = s.trig_en && !s.exposing;
				PORT_SRC_USER: n.port_out[i] = s.port_src[i][PORT_USER_BIT];
				PORT_SRC_STROBE: begin
					n.port_out[i] = (s.phase[i] == FLASH_ON) ?
						s.cfg[i].polarity : !s.cfg[i].polarity;
				end
				default: n.port_out[i] = 1'b0;
			endcase
		end
	end

	// Single state register; reset loads constants only.
	// The reset is synchronous, so the struct simply loads its start values
	// in place of n at any edge that sees aresetn low.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.trig_en <= 1'b0;
			s.trig_src <= TRIG_SRC_INPUT_A;
			s.exp_mode <= EXPOSURE_LEVEL;
			s.shutter <= SHUTTER_RST;
			s.timebase <= TIMEBASE_RST;
			for (int i = 0; i < 4; i++) begin
				s.cfg[i].polarity <= FLASH_POL_HIGH;
				s.cfg[i].delay <= 12'h0;
				s.cfg[i].width <= 12'h0;
				s.phase[i] <= FLASH_IDLE;
			end
		end else begin
			s <= n;
		end
	end

endmodule : trig_flash_ctrl

// ==== verilog/trig_flash_pkg.sv ====
// Contract
// - Trigger source codes: 0x00, 0x01, 0x07 software.
// - Reset selects first input port as source.
// - Two exposure modes: programmable and level.
// - Reset selects level exposure mode.
// - Trigger enable arms triggering; clear disables it.
// - Enable reads true/false, resets disabled.
// - Enable, source, mode read back together.
// - Strobe settings refused unless port sources strobe.
// - Four strobe channels indexed 0 to 3.
// - Per-channel strobe enable turns pulses on/off.
// - Per-channel polarity, resets high-active.
// - Per-channel delay 0 to 4095, resets 0.
// - Per-channel duration 0 to 4095, resets 0.
// - Channel enable, polarity, delay, duration readable.
// - Shared time base 1 to 85, resets 1.
package trig_flash_pkg;

	// Register byte addresses on the control bus.
	localparam logic [7:0] ADDR_TRIG_CTRL = 8'h00;
	localparam logic [7:0] ADDR_SOFT_TRIG = 8'h04;
	localparam logic [7:0] ADDR_SHUTTER = 8'h08;
	localparam logic [7:0] ADDR_TIMEBASE = 8'h0c;
	localparam logic [7:0] ADDR_PORT_SRC = 8'h10;
	localparam logic [7:0] ADDR_STATUS = 8'h14;
	localparam logic [3:0] ADDR_FLASH_HI = 4'h2;

	// Field positions.
	localparam int TRIG_EN_BIT = 0;
	localparam int TRIG_SRC_LSB = 8;
	localparam int TRIG_MODE_BIT = 16;
	localparam int FLASH_DELAY_LSB = 0;
	localparam int FLASH_WIDTH_LSB = 12;
	localparam int FLASH_EN_BIT = 28;
	localparam int FLASH_POL_BIT = 29;
	localparam int PORT_USER_BIT = 7;

	// Codes.
	localparam logic [2:0] TRIG_SRC_INPUT_A = 3'h0;
	localparam logic [2:0] TRIG_SRC_INPUT_B = 3'h1;
	localparam logic [2:0] TRIG_SRC_SOFT = 3'h7;
	localparam logic EXPOSURE_PROGRAMMABLE = 1'b0;
	localparam logic EXPOSURE_LEVEL = 1'b1;
	localparam logic FLASH_POL_LOW = 1'b0;
	localparam logic FLASH_POL_HIGH = 1'b1;
	localparam logic [2:0] PORT_SRC_INTEGRATE = 3'h0;
	localparam logic [2:0] PORT_SRC_READY = 3'h1;
	localparam logic [2:0] PORT_SRC_USER = 3'h3;
	localparam logic [2:0] PORT_SRC_STROBE = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Limits and values after reset.
	localparam logic [6:0] TIMEBASE_MIN = 7'h01;
	localparam logic [6:0] TIMEBASE_MAX = 7'h55;
	localparam logic [6:0] TIMEBASE_RST = 7'h01;
	localparam logic [15:0] SHUTTER_RST = 16'h00c8;

	// One strobe time-base unit, scaled by the time base register.
	localparam int CLK_PERIOD_NS = 5;
	localparam int FLASH_UNIT_NS = 1000;
	localparam logic [7:0] FLASH_UNIT_CYCLES = 8'(FLASH_UNIT_NS / CLK_PERIOD_NS);

	typedef enum logic [1:0] {FLASH_IDLE, FLASH_WAIT, FLASH_ON} flash_phase_t;

	typedef struct packed {
		logic enable;
		logic polarity;
		logic [11:0] delay;
		logic [11:0] width;
	} flash_cfg_t;

	typedef struct packed {
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic trig_en;
		logic [2:0] trig_src;
		logic exp_mode;
		logic [15:0] shutter;
		logic [6:0] timebase;
		logic [3:0][7:0] port_src;
		flash_cfg_t [3:0] cfg;
		flash_phase_t [3:0] phase;
		logic [3:0][11:0] cnt;
		logic [7:0] unit_cnt;
		logic [6:0] tb_cnt;
		logic [1:0] sync_a;
		logic [1:0] sync_b;
		logic soft_pulse;
		logic trig_prev;
		logic exposing;
		logic [15:0] exp_cnt;
		logic [3:0] port_out;
	} state_t;

endpackage : trig_flash_pkg
